// ---- core/framer_pkg.sv ----
// constants and helpers for the serial framing processor
package framer_pkg;
  // clock and watchdog timebase
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_NS     = 1000;
  localparam int TICK_CYCLES = TICK_NS / (1_000_000_000 / CLK_HZ);
  // register indices and byte addresses
  localparam logic [13:0] IDX_END_COUNT1  = 14'h00A4;
  localparam logic [13:0] IDX_END_CODE1   = 14'h00A5;
  localparam logic [13:0] IDX_END_COUNT2  = 14'h0144;
  localparam logic [13:0] IDX_END_CODE2   = 14'h0145;
  localparam logic [13:0] ADDR_END_COUNT1 = IDX_END_COUNT1 << 2;
  localparam logic [13:0] ADDR_END_CODE1  = IDX_END_CODE1 << 2;
  localparam logic [13:0] ADDR_END_COUNT2 = IDX_END_COUNT2 << 2;
  localparam logic [13:0] ADDR_END_CODE2  = IDX_END_CODE2 << 2;
  localparam logic [13:0] ADDR_CTRL       = 14'h0000;
  localparam logic [13:0] ADDR_CODES      = 14'h0004;
  localparam logic [13:0] ADDR_FRAMES     = 14'h0008;
  localparam logic [13:0] ADDR_TIMER0     = 14'h000C;
  localparam logic [13:0] ADDR_STATUS     = 14'h0010;
  localparam logic [13:0] ADDR_RX_LEN     = 14'h0014;
  localparam logic [13:0] ADDR_TX_START   = 14'h0018;
  // areas: rx 0x1000-0x17FC, tx 0x2000-0x23FC
  localparam logic [2:0]  RX_AREA_TAG     = 3'h2;
  localparam logic [3:0]  TX_AREA_TAG     = 4'h8;
  // control and status bit positions
  localparam int C_FRAMED = 0, C_ASCII = 1, C_RX_TRANSP = 2, C_TX_TRANSP = 3;
  localparam int C_SUM = 4, C_HDR = 5, C_TRL = 6;
  localparam int S_REQ = 0, S_ERR = 1, S_TXBUSY = 2, S_HOLD = 3;
  // reset values and codes
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [23:0] CODES_RST     = 24'h100210;
  localparam logic [15:0] FRAMES_RST    = 16'h0302;
  localparam logic [15:0] TIMER0_RST    = 16'h03E8;
  localparam logic [15:0] END_COUNT_RST = 16'h01FF;
  localparam logic [15:0] END_CODE_RST  = 16'h0D0A;
  localparam logic [15:0] END_CODE_OFF  = 16'hFFFF;
  localparam logic [7:0]  CR            = 8'h0D;
  localparam logic [7:0]  LF            = 8'h0A;
  localparam logic [9:0]  BANK_BYTES    = 10'h200;
  localparam logic [8:0]  TX_BYTES      = 9'h100;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {RX_HDR, RX_DATA, RX_SUM} rx_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA, TX_TRL} tx_state_e;

  // bit 4 set when the character is a hex digit 0-9 or uppercase A-F
  function automatic logic [4:0] hex_nibble(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    else if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c[3:0] + 4'h9)};
    else return 5'h00;
  endfunction

  function automatic logic [7:0] nibble_char(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction
endpackage

// ---- core/serial_rx_tx_framing_processor.sv ----
// serial framing processor: byte link, host handshake, axi4-lite slave
`timescale 1ns/1ps
// Notes on behaviour
// - escape never hides frame or end-code bytes
// - receive drops escapes, converts, then stores
// - end code or count raises read request
// - transmit payload, ascii-converted when enabled
// - escape precedes transparent and escape bytes
// - framed receive matches header, trailer frames
// - sum check over message when enabled
// - framed store, request on code/count/trailer
// - framed transmit keeps header, payload, trailer
// - convert and escape payload bytes only
// - end code is any single byte
// - later bytes wait in holding bank
// - cr then lf in time ends message
// - cr timeout keeps cr, flags error
// - custom code stored, then request raised
// - code ffff disables end-code detection
// - end code compared after ascii conversion
// - count reached raises request, default 511
// - escape dropped, next byte is data
// - read complete releases next buffered data
module serial_rx_tx_framing_processor (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [13:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [13:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // serial device byte link
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  output logic [7:0]       tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // host handshake
  output logic             rx_read_request,
  output logic             rx_error_detect,
  input  wire logic        rx_read_complete
);
  logic [7:0]  ctrl;
  logic [23:0] codes;
  logic [15:0] frames;
  logic [15:0] timer0;
  logic [15:0] end_count1;
  logic [15:0] end_code1;
  logic [15:0] end_count2;
  logic [15:0] end_code2;
  logic [7:0]  rx_mem [0:1023];
  logic [7:0]  tx_mem [0:255];

  wire       framed   = ctrl[framer_pkg::C_FRAMED];
  wire       ascii    = ctrl[framer_pkg::C_ASCII];
  wire       rx_transp = ctrl[framer_pkg::C_RX_TRANSP];
  wire       tx_transp = ctrl[framer_pkg::C_TX_TRANSP];
  wire       sum_en   = ctrl[framer_pkg::C_SUM];
  wire       hdr_en   = framed & ctrl[framer_pkg::C_HDR];
  wire       trl_en   = framed & ctrl[framer_pkg::C_TRL];
  wire [7:0] rx_esc   = codes[7:0];
  wire [7:0] tx_code  = codes[15:8];
  wire [7:0] tx_esc   = codes[23:16];
  wire [7:0] hdr_code = frames[7:0];
  wire [7:0] trl_code = frames[15:8];

  // ---------------- axi4-lite write channel ----------------
  logic        aw_got;
  logic        w_got;
  logic [13:0] waddr;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;

  wire a_ctrl   = waddr == framer_pkg::ADDR_CTRL;
  wire a_codes  = waddr == framer_pkg::ADDR_CODES;
  wire a_frames = waddr == framer_pkg::ADDR_FRAMES;
  wire a_timer  = waddr == framer_pkg::ADDR_TIMER0;
  wire a_status = waddr == framer_pkg::ADDR_STATUS;
  wire a_start  = waddr == framer_pkg::ADDR_TX_START;
  wire a_cnt1   = waddr == framer_pkg::ADDR_END_COUNT1;
  wire a_code1  = waddr == framer_pkg::ADDR_END_CODE1;
  wire a_cnt2   = waddr == framer_pkg::ADDR_END_COUNT2;
  wire a_code2  = waddr == framer_pkg::ADDR_END_CODE2;
  wire a_tx     = waddr[13:10] == framer_pkg::TX_AREA_TAG;
  wire w_map    = a_ctrl | a_codes | a_frames | a_timer | a_status
                | a_start | a_cnt1 | a_code1 | a_cnt2 | a_code2 | a_tx;
  wire do_write = aw_got & w_got & ~bvalid;
  wire wr_start = do_write & a_start;
  wire err_wclr = do_write & a_status & ws_q[0] & wd_q[framer_pkg::S_ERR];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= framer_pkg::RESP_OKAY;
      waddr   <= 14'h0000;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end else begin
      if (awvalid & awready) begin
        aw_got  <= 1'b1;
        awready <= 1'b0;
        waddr   <= awaddr;
      end
      if (wvalid & wready) begin
        w_got  <= 1'b1;
        wready <= 1'b0;
        wd_q   <= wdata;
        ws_q   <= wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= w_map ? framer_pkg::RESP_OKAY : framer_pkg::RESP_SLVERR;
      end
      if (bvalid & bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl       <= framer_pkg::CTRL_RST;
      codes      <= framer_pkg::CODES_RST;
      frames     <= framer_pkg::FRAMES_RST;
      timer0     <= framer_pkg::TIMER0_RST;
      end_count1 <= framer_pkg::END_COUNT_RST;
      end_code1  <= framer_pkg::END_CODE_RST;
      end_count2 <= framer_pkg::END_COUNT_RST;
      end_code2  <= framer_pkg::END_CODE_RST;
    end else if (do_write) begin
      if (a_ctrl)
        ctrl <= 8'(framer_pkg::merge({24'h0, ctrl}, wd_q, ws_q));
      if (a_codes)
        codes <= 24'(framer_pkg::merge({8'h0, codes}, wd_q, ws_q));
      if (a_frames)
        frames <= 16'(framer_pkg::merge({16'h0, frames}, wd_q, ws_q));
      if (a_timer)
        timer0 <= 16'(framer_pkg::merge({16'h0, timer0}, wd_q, ws_q));
      if (a_cnt1)
        end_count1 <= 16'(framer_pkg::merge({16'h0, end_count1}, wd_q, ws_q));
      if (a_code1)
        end_code1 <= 16'(framer_pkg::merge({16'h0, end_code1}, wd_q, ws_q));
      if (a_cnt2)
        end_count2 <= 16'(framer_pkg::merge({16'h0, end_count2}, wd_q, ws_q));
      if (a_code2)
        end_code2 <= 16'(framer_pkg::merge({16'h0, end_code2}, wd_q, ws_q));
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_write & a_tx & ws_q[0]) tx_mem[waddr[9:2]] <= wd_q[7:0];
  end

  // ---------------- receive path ----------------
  framer_pkg::rx_state_e rx_state;
  logic        esc_pend;
  logic        nib_half;
  logic [3:0]  nib_hi;
  logic        cr_wait;
  logic [15:0] cr_timer;
  logic [4:0]  tick_cnt;
  logic        wr_bank;
  logic        rd_bank;
  logic        hold_done;
  logic [9:0]  count;
  logic [9:0]  rd_len;
  logic [9:0]  hold_len;
  logic [7:0]  sum;

  wire tick = tick_cnt == 5'(framer_pkg::TICK_CYCLES - 1);
  wire in_data = ~framed | rx_state == framer_pkg::RX_DATA
               | (rx_state == framer_pkg::RX_HDR & ~hdr_en);
  wire hdr_hit = rx_valid & hdr_en & rx_state == framer_pkg::RX_HDR
               & rx_byte == hdr_code;
  wire trl_hit = rx_valid & in_data & trl_en & rx_byte == trl_code;
  wire pay_byte = rx_valid & in_data & ~trl_hit;
  wire esc_drop = pay_byte & rx_transp & ~esc_pend & rx_byte == rx_esc;
  wire char_ok = pay_byte & ~esc_drop;
  wire [4:0] nib = framer_pkg::hex_nibble(rx_byte);
  wire st_we = char_ok & (~ascii | nib_half);
  wire [7:0] st_data = ascii ? {nib_hi, nib[3:0]} : rx_byte;
  wire store_ok = st_we & ~hold_done;
  wire [9:0] next_count = count + 10'd1;
  wire [9:0] end_lim = (end_count1 == 16'h0000
                       || end_count1 > {6'h00, framer_pkg::BANK_BYTES})
                     ? framer_pkg::BANK_BYTES : end_count1[9:0];
  wire code_off = end_code1 == framer_pkg::END_CODE_OFF;
  wire code_dflt = end_code1 == framer_pkg::END_CODE_RST;
  wire crlf_hit = store_ok & code_dflt & cr_wait & st_data == framer_pkg::LF;
  wire code_hit = store_ok & ~code_off & ~code_dflt
                & st_data == end_code1[7:0];
  wire cnt_hit = store_ok & next_count == end_lim;
  wire end_evt = crlf_hit | code_hit | cnt_hit | (trl_hit & ~hold_done);
  wire [9:0] ev_len = store_ok ? next_count : count;
  wire ack = rx_read_request & rx_read_complete;
  wire present_now = end_evt & ~rx_read_request & ~hold_done;
  wire present_hold = hold_done & ~rx_read_request;
  wire cr_expire = cr_wait & tick & cr_timer <= 16'h0001 & ~store_ok;
  wire sum_bad = rx_valid & rx_state == framer_pkg::RX_SUM & rx_byte != sum;
  wire overrun = st_we & hold_done;
  wire hex_bad = char_ok & ascii & ~nib[4];
  wire err_set = cr_expire | sum_bad | overrun | hex_bad;

  always_ff @(posedge core_clk) begin
    if (store_ok) rx_mem[{wr_bank, count[8:0]}] <= st_data;
  end

  always_ff @(posedge core_clk) begin
    if (rst) tick_cnt <= 5'h00;
    else tick_cnt <= tick ? 5'h00 : tick_cnt + 5'h01;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_state <= framer_pkg::RX_HDR;
      esc_pend <= 1'b0;
      nib_half <= 1'b0;
      nib_hi   <= 4'h0;
      sum      <= 8'h00;
    end else if (trl_hit) begin
      rx_state <= sum_en ? framer_pkg::RX_SUM : framer_pkg::RX_HDR;
      esc_pend <= 1'b0;
      nib_half <= 1'b0;
    end else if (rx_valid & rx_state == framer_pkg::RX_SUM) begin
      rx_state <= framer_pkg::RX_HDR;
      sum      <= 8'h00;
    end else begin
      if (hdr_hit) rx_state <= framer_pkg::RX_DATA;
      if (hdr_hit) sum <= 8'h00;
      else if (pay_byte) sum <= sum + rx_byte;
      if (esc_drop) esc_pend <= 1'b1;
      else if (char_ok) esc_pend <= 1'b0;
      if (char_ok & ascii) nib_half <= ~nib_half;
      if (char_ok & ascii & ~nib_half) nib_hi <= nib[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cr_wait  <= 1'b0;
      cr_timer <= 16'h0000;
    end else if (store_ok) begin
      cr_wait  <= code_dflt & st_data == framer_pkg::CR;
      cr_timer <= timer0;
    end else if (cr_expire) begin
      cr_wait <= 1'b0;
    end else if (cr_wait & tick) begin
      cr_timer <= cr_timer - 16'h0001;
    end
  end

  // two banks; one read, one filling
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_read_request <= 1'b0;
      rx_error_detect <= 1'b0;
      wr_bank   <= 1'b0;
      rd_bank   <= 1'b0;
      hold_done <= 1'b0;
      count     <= 10'h000;
      rd_len    <= 10'h000;
      hold_len  <= 10'h000;
    end else begin
      // error set wins over clear
      if (err_set) rx_error_detect <= 1'b1;
      else if (err_wclr | ack) rx_error_detect <= 1'b0;
      if (ack) rx_read_request <= 1'b0;
      if (present_now | present_hold) begin
        rx_read_request <= 1'b1;
        rd_bank <= wr_bank;
        wr_bank <= ~wr_bank;
        count   <= 10'h000;
        rd_len  <= present_hold ? hold_len : ev_len;
      end else if (end_evt) begin
        hold_done <= 1'b1;
        hold_len  <= ev_len;
      end else if (store_ok) begin
        count <= next_count;
      end
      if (present_hold) hold_done <= 1'b0;
    end
  end

  // ---------------- transmit path ----------------
  framer_pkg::tx_state_e tx_state;
  logic [8:0] tx_len;
  logic [8:0] tx_idx;
  logic       tx_lo;
  logic       esc_done;
  logic       tx_esc_out;

  wire [7:0] pay_raw = tx_mem[tx_idx[7:0]];
  wire [7:0] pay_char = ascii
    ? framer_pkg::nibble_char(tx_lo ? pay_raw[3:0] : pay_raw[7:4]) : pay_raw;
  wire [7:0] cur_char = tx_state == framer_pkg::TX_HDR ? hdr_code
                      : tx_state == framer_pkg::TX_TRL ? trl_code : pay_char;
  wire need_esc = tx_state == framer_pkg::TX_DATA & tx_transp & ~esc_done
                & (cur_char == tx_code | cur_char == tx_esc);
  wire tx_load = tx_state != framer_pkg::TX_IDLE & (~tx_valid | tx_ready);
  wire tx_busy = tx_state != framer_pkg::TX_IDLE | tx_valid;
  wire byte_end = ~ascii | tx_lo;
  wire last_byte = tx_idx + 9'h001 == tx_len;
  wire [8:0] start_len = wd_q[8] ? framer_pkg::TX_BYTES : wd_q[8:0];
  framer_pkg::tx_state_e trl_or_idle;
  assign trl_or_idle = trl_en ? framer_pkg::TX_TRL : framer_pkg::TX_IDLE;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state   <= framer_pkg::TX_IDLE;
      tx_len     <= 9'h000;
      tx_idx     <= 9'h000;
      tx_lo      <= 1'b0;
      esc_done   <= 1'b0;
      tx_esc_out <= 1'b0;
      tx_valid   <= 1'b0;
      tx_byte    <= 8'h00;
    end else if (wr_start & tx_state == framer_pkg::TX_IDLE) begin
      tx_len <= start_len;
      tx_idx <= 9'h000;
      tx_lo  <= 1'b0;
      if (hdr_en) tx_state <= framer_pkg::TX_HDR;
      else if (start_len != 9'h000) tx_state <= framer_pkg::TX_DATA;
      else tx_state <= trl_or_idle;
    end else if (tx_load) begin
      tx_valid   <= 1'b1;
      tx_byte    <= need_esc ? tx_esc : cur_char;
      tx_esc_out <= need_esc;
      esc_done   <= need_esc;
      if (!need_esc) begin
        case (tx_state)
          framer_pkg::TX_HDR: begin
            tx_state <= tx_len != 9'h000 ? framer_pkg::TX_DATA : trl_or_idle;
          end
          framer_pkg::TX_DATA: begin
            tx_lo <= ~byte_end;
            if (byte_end) tx_idx <= tx_idx + 9'h001;
            if (byte_end & last_byte) tx_state <= trl_or_idle;
          end
          default: tx_state <= framer_pkg::TX_IDLE;
        endcase
      end
    end else if (tx_valid & tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // ---------------- axi4-lite read channel ----------------
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (araddr == framer_pkg::ADDR_CTRL) rd_val = {24'h0, ctrl};
    else if (araddr == framer_pkg::ADDR_CODES) rd_val = {8'h0, codes};
    else if (araddr == framer_pkg::ADDR_FRAMES) rd_val = {16'h0, frames};
    else if (araddr == framer_pkg::ADDR_TIMER0) rd_val = {16'h0, timer0};
    else if (araddr == framer_pkg::ADDR_STATUS) begin
      rd_val[framer_pkg::S_REQ]    = rx_read_request;
      rd_val[framer_pkg::S_ERR]    = rx_error_detect;
      rd_val[framer_pkg::S_TXBUSY] = tx_busy;
      rd_val[framer_pkg::S_HOLD]   = hold_done;
    end
    else if (araddr == framer_pkg::ADDR_RX_LEN) rd_val = {22'h0, rd_len};
    else if (araddr == framer_pkg::ADDR_TX_START) rd_val = {23'h0, tx_len};
    else if (araddr == framer_pkg::ADDR_END_COUNT1) rd_val = {16'h0, end_count1};
    else if (araddr == framer_pkg::ADDR_END_CODE1) rd_val = {16'h0, end_code1};
    else if (araddr == framer_pkg::ADDR_END_COUNT2) rd_val = {16'h0, end_count2};
    else if (araddr == framer_pkg::ADDR_END_CODE2) rd_val = {16'h0, end_code2};
    else if (araddr[13:11] == framer_pkg::RX_AREA_TAG)
      rd_val = {24'h0, rx_mem[{rd_bank, araddr[10:2]}]};
    else if (araddr[13:10] == framer_pkg::TX_AREA_TAG)
      rd_val = {24'h0, tx_mem[araddr[9:2]]};
    else rd_hit = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= framer_pkg::RESP_OKAY;
    end else if (arvalid & arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_val;
      rresp   <= rd_hit ? framer_pkg::RESP_OKAY : framer_pkg::RESP_SLVERR;
    end else if (rvalid & rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence esc_sent;
    tx_valid && tx_ready && tx_esc_out;
  endsequence
  sequence hdr_sent;
    tx_load && tx_state == framer_pkg::TX_HDR;
  endsequence

  req_hold_a: assert property (
    rx_read_request && !rx_read_complete |=> rx_read_request)
    else $error("read request dropped before complete");
  req_drop_a: assert property (
    ack |=> !rx_read_request)
    else $error("read request stayed after complete");
  esc_drop_a: assert property (
    esc_drop |-> !st_we ##1 esc_pend)
    else $error("receive escape byte was stored");
  tx_escape_a: assert property (
    esc_sent |=> tx_valid && !tx_esc_out
                 && (tx_byte == tx_code || tx_byte == tx_esc))
    else $error("escape not followed by escaped byte");
  hdr_raw_a: assert property (
    hdr_sent |=> tx_valid && tx_byte == $past(hdr_code))
    else $error("header byte altered on transmit");
  end_count_a: assert property (
    cnt_hit && !rx_read_request && !hold_done
      |=> rx_read_request && rd_len == end_lim)
    else $error("end count did not raise request");
  end_code_a: assert property (
    code_hit && !rx_read_request && !hold_done
      |=> rx_read_request && rd_len == $past(next_count))
    else $error("custom end code did not raise request");
  crlf_end_a: assert property (
    crlf_hit && !rx_read_request && !hold_done |=> rx_read_request)
    else $error("cr lf did not raise request");
  cr_timeout_a: assert property (
    cr_expire |=> rx_error_detect && !cr_wait)
    else $error("cr timeout did not flag error");
  hold_bank_a: assert property (
    end_evt && rx_read_request && !hold_done
      |=> hold_done && hold_len == $past(ev_len))
    else $error("held data not kept for next read");
endmodule

// ---- sim/serial_dev_model.sv ----
// far-side serial device model: sends bytes, takes bytes with stalls
`timescale 1ns/1ps
module serial_dev_model (
  // clock
  input  wire logic       core_clk,
  // byte link
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] got [$];
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge core_clk);
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    // idle line never shows the stale byte
    rx_byte <= ~b;
  endtask
  // taker stalls every other cycle
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_byte);
    tx_ready <= ~tx_ready;
  end
endmodule

// ---- sim/tb_top.sv ----
// self-checking testbench for the serial framing processor
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 0, rst = 1, rx_read_complete = 0;
  logic [13:0] awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  rx_byte, tx_byte;
  logic        rx_valid, tx_valid, tx_ready, rx_read_request, rx_error_detect;
  int          num_errors = 0, cmp_count = 0;
  serial_rx_tx_framing_processor uut (.*);
  serial_dev_model dev (.core_clk(core_clk), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  initial forever #25 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && ++n < 200);
    bready <= 0;
    check(bvalid, 1'b1);
    check(bresp, framer_pkg::RESP_OKAY);
  endtask
  task automatic rdw(input logic [13:0] a);
    int n = 0;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 0;
    end while (!rvalid && ++n < 200);
    rready <= 0; rd = rdata; rs = rresp;
    check(rvalid, 1'b1);
  endtask
  task automatic wait_req();
    int n = 0;
    while (!rx_read_request && ++n < 40) @(posedge core_clk);
  endtask
  task automatic complete();
    @(posedge core_clk) rx_read_complete <= 1;
    @(posedge core_clk) rx_read_complete <= 0;
    @(posedge core_clk);
    check(rx_read_request, 1'b0);
  endtask
  task automatic t_regs();
    rdw(framer_pkg::ADDR_END_COUNT1); check(rd, 32'h000001FF);
    rdw(framer_pkg::ADDR_END_CODE1); check(rd, 32'h00000D0A);
    rdw(14'h0300); check(rs, framer_pkg::RESP_SLVERR);
  endtask
  // custom code stored and requested; length and both bytes read back
  task automatic t_code();
    wr(framer_pkg::ADDR_END_CODE1, 32'h00000033);
    dev.send(8'h41);
    dev.send(8'h33);
    wait_req(); check(rx_read_request, 1'b1);
    rdw(framer_pkg::ADDR_RX_LEN); check(rd, 32'h2);
    rdw(14'h1000); check(rd, 32'h41);
    rdw(14'h1004); check(rd, 32'h33);
    complete();
  endtask
  task automatic t_count();
    wr(framer_pkg::ADDR_END_CODE1, 32'h0000FFFF);
    wr(framer_pkg::ADDR_END_COUNT1, 32'h00000002);
    dev.send(8'hFF);
    @(posedge core_clk); check(rx_read_request, 1'b0);
    dev.send(8'h0D);
    wait_req(); check(rx_read_request, 1'b1);
    rdw(framer_pkg::ADDR_RX_LEN); check(rd, 32'h2);
    rdw(14'h1000); check(rd, 32'hFF);
    // second block ends while the first is still up
    dev.send(8'h44);
    dev.send(8'h55);
    complete();
    wait_req(); check(rx_read_request, 1'b1);
    rdw(14'h1000); check(rd, 32'h44);
    complete();
  endtask
  // hex pairs with an escape inside; end code on binary value
  task automatic t_ascii();
    wr(framer_pkg::ADDR_CTRL, 32'h00000006);
    wr(framer_pkg::ADDR_END_COUNT1, 32'h000001FF);
    wr(framer_pkg::ADDR_END_CODE1, 32'h0000005A);
    dev.send(8'h31);
    dev.send(8'h10);
    dev.send(8'h32);
    dev.send(8'h35);
    dev.send(8'h41);
    wait_req(); check(rx_read_request, 1'b1);
    rdw(framer_pkg::ADDR_RX_LEN); check(rd, 32'h2);
    rdw(14'h1000); check(rd, 32'h12);
    rdw(14'h1004); check(rd, 32'h5A);
    check(rx_error_detect, 1'b0);
    complete();
  endtask
  // default cr lf end, then a lone cr left to time out
  task automatic t_crlf();
    wr(framer_pkg::ADDR_CTRL, 32'h00000000);
    wr(framer_pkg::ADDR_END_CODE1, 32'h00000D0A);
    wr(framer_pkg::ADDR_TIMER0, 32'h00000002);
    dev.send(8'h41);
    dev.send(8'h0D);
    @(posedge core_clk); check(rx_read_request, 1'b0);
    dev.send(8'h0A);
    wait_req(); check(rx_read_request, 1'b1);
    rdw(framer_pkg::ADDR_RX_LEN); check(rd, 32'h3);
    complete();
    dev.send(8'h0D);
    repeat (50) @(posedge core_clk);
    check(rx_error_detect, 1'b1);
    check(rx_read_request, 1'b0);
  endtask
  task automatic t_tx();
    int n = 0;
    wr(framer_pkg::ADDR_CTRL, 32'h00000008);
    wr(14'h2000, 32'h00000002);
    wr(framer_pkg::ADDR_TX_START, 32'h00000001);
    while (dev.got.size() < 2 && ++n < 100) @(posedge core_clk);
    check(dev.got.size(), 32'd2);
    check(dev.got[0], 8'h10);
    check(dev.got[1], 8'h02);
    // framed: header equal to transparent code stays bare
    wr(framer_pkg::ADDR_CTRL, 32'h0000006B);
    wr(14'h2000, 32'h0000002A);
    wr(framer_pkg::ADDR_TX_START, 32'h00000001);
    n = 0;
    while (dev.got.size() < 6 && ++n < 100) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    check(dev.got.size(), 32'd6);
    check(dev.got[2], 8'h02);
    check(dev.got[3], 8'h32);
    check(dev.got[4], 8'h41);
    check(dev.got[5], 8'h03);
  endtask
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // under 300 cycles of tests; limit well above
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 0;
    t_regs(); t_code(); t_count(); t_ascii(); t_crlf(); t_tx();
    conclude();
  end
endmodule
